// ### acs_regs.svh
// constants for the conversion sequencer: field positions, reset values, timing counts
// assumes inclusion by bare name from the package and the sequencer module
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ---------------------------------------------------------------
// widths and field positions
// ---------------------------------------------------------------
`define ACS_RES_W        12
`define ACS_JUSTIFY_SHIFT 4
`define ACS_DIV_W        6
`define ACS_TRIG_W       5
`define ACS_CONV_BITS    4'hc

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ACS_RST_RESULT   16'h0000
`define ACS_RST_SUM      20'h00000
`define ACS_RST_DIV      6'h00

// ---------------------------------------------------------------
// timing: extra instruction period before converting on the rc clock
// ---------------------------------------------------------------
`define ACS_INSTR_NS     400
`define ACS_CLK_NS       100
`define ACS_RC_DELAY_CYC ((`ACS_INSTR_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)

`endif

// ### acs_pkg.sv
// types for the conversion sequencer
// assumes acs_regs.svh sits in the same folder
`default_nettype none
`include "acs_regs.svh"

package acs_pkg;

  // control bits written by software
  typedef struct packed {
    logic                      enable;
    logic                      continuous_repeat;
    logic                      result_justify_select;
    logic                      converter_rc_clock_option;
    logic                      previous_source_select;
    logic                      double_sample_enable;
    logic                      conversion_irq_enable;
    logic                      global_irq_enable;
    logic [`ACS_DIV_W-1:0]     clock_divide;
    logic [`ACS_TRIG_W-1:0]    trigger_source_select;
  } acs_ctrl_t;

  // status bits shown to software
  typedef struct packed {
    logic start_busy;
    logic conversion_done_flag;
    logic computation_pending_flag;
    logic threshold_irq_flag;
    logic converter_off;
    logic wake_request;
    logic vector_request;
    logic trigger_latched;
  } acs_stat_t;

  typedef enum logic [2:0] {
    ACS_IDLE,
    ACS_RC_WAIT,
    ACS_CONVERT,
    ACS_FINISH,
    ACS_COMPUTE
  } acs_state_t;

endpackage
`default_nettype wire

// ### acs_sequencer.sv
// conversion sequencer around a 12-bit successive-approximation converter
// assumes the analog core delivers a result when asked and that the
// conversion clock tick is derived here from i_sys_clk or i_rc_tick
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"

// How it works
// - done flag set on every completion
// - done flag cleared only by software
// - completion in sleep wakes, vectors if enabled
// - result left or right justified by select
// - software result writes stored justified by select
// - start by bit, trigger or continuous retrigger
// - old result moved to previous when selected
// - completion clears start unless repeating, sets flags, sums
// - threshold test every or every second conversion
// - threshold result computed after conversion completes
// - reset clears registers and aborts conversion
// - rc clock waits one instruction before converting
// - sleep without interrupt turns converter off
// - trigger in sleep on rc clock converts
// - trigger in sleep otherwise latched until wake
// - trigger rising edge sets start bit
// - hold capacitor never discharged between conversions
// - clock is even system divide or rc
// - control logic runs on the system clock; conversion steps wait for the conversion tick
module acs_sequencer (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_rc_tick,
  // configuration
  input  wire acs_pkg::acs_ctrl_t       i_ctrl,
  input  wire logic                     i_sleep,
  // software strobes
  input  wire logic                     i_start_set,
  input  wire logic                     i_start_clr,
  input  wire logic                     i_done_clr,
  input  wire logic                     i_math_clr,
  input  wire logic                     i_thresh_clr,
  input  wire logic                     i_result_wr,
  input  wire logic [`ACS_RES_W-1:0]    i_result_wdata,
  // trigger sources and threshold setup
  input  wire logic [31:0]              i_trig_sources,
  input  wire logic [`ACS_RES_W-1:0]    i_setpoint,
  input  wire logic [`ACS_RES_W-1:0]    i_threshold,
  // analog core
  input  wire logic [`ACS_RES_W-1:0]    i_core_result,
  output logic                          o_core_sample,
  output logic                          o_hold_discharge,
  // results and status
  output logic [15:0]                   o_result_pair,
  output logic [15:0]                   o_previous_result,
  output logic [19:0]                   o_sum_register,
  output logic [`ACS_RES_W:0]           o_error_value,
  output acs_pkg::acs_stat_t            o_status
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  acs_pkg::acs_state_t         state;
  acs_pkg::acs_state_t         next_state;
  logic [`ACS_DIV_W:0]         div_cnt;
  logic [3:0]                  bit_cnt;
  logic [2:0]                  rc_cnt;
  logic                        trig_prev;
  logic                        sample_phase;
  logic [`ACS_RES_W-1:0]       raw_result;
  logic [`ACS_RES_W-1:0]       conv_data;
  logic                        start_busy;
  logic                        done_flag;
  logic                        math_flag;
  logic                        thresh_flag;
  logic                        conv_off;
  logic                        trig_latched;
  logic                        wake_req;
  logic                        vector_req;
  logic [15:0]                 result_pair;
  logic [15:0]                 previous_result;
  logic [19:0]                 sum_register;
  logic [`ACS_RES_W:0]         error_value;
  logic                        core_sample;

  // ---------------------------------------------------------------
  // conversion clock tick
  // ---------------------------------------------------------------
  // even divide 2*(n+1) of the system clock, or the rc tick
  wire [`ACS_DIV_W:0] div_top  = {i_ctrl.clock_divide, 1'b1};
  wire                div_tick = (div_cnt == div_top);
  wire                tick     = i_ctrl.converter_rc_clock_option ? i_rc_tick : div_tick;

  // divider counter
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b || div_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // start decoding
  // ---------------------------------------------------------------
  wire trig_now   = i_trig_sources[i_ctrl.trigger_source_select];
  wire trig_rise  = trig_now & ~trig_prev;
  wire sleep_hold = i_sleep & ~i_ctrl.converter_rc_clock_option;
  // a latched trigger fires once sleep ends and sets the start bit like a live edge
  wire trig_fire  = (trig_rise | trig_latched) & ~sleep_hold;
  wire enabled    = i_ctrl.enable & ~conv_off;
  // start bit or trigger, only while enabled and idle
  wire go_req     = enabled & (state == acs_pkg::ACS_IDLE)
                  & (start_busy | trig_fire);
  wire finishing  = (state == acs_pkg::ACS_FINISH) & tick;
  wire computing  = (state == acs_pkg::ACS_COMPUTE) & tick;
  wire test_now   = computing & (~i_ctrl.double_sample_enable | sample_phase);
  wire retrigger  = finishing & i_ctrl.continuous_repeat;

  // ---------------------------------------------------------------
  // result shaping
  // ---------------------------------------------------------------
  wire [15:0] right_just = {4'h0, raw_result};
  wire [15:0] left_just  = {raw_result, 4'h0};
  wire [15:0] new_result = i_ctrl.result_justify_select ? left_just : right_just;
  // software writes are justified by the same select as conversion results
  wire [15:0] sw_result  = i_ctrl.result_justify_select ? {i_result_wdata, 4'h0}
                                                        : {4'h0, i_result_wdata};
  wire [`ACS_RES_W:0] err_calc = {1'b0, raw_result} - {1'b0, i_setpoint};
  wire [`ACS_RES_W-1:0] err_mag = err_calc[`ACS_RES_W] ? (~err_calc[`ACS_RES_W-1:0] + 12'h001)
                                                      : err_calc[`ACS_RES_W-1:0];
  wire thresh_hit = err_mag > i_threshold;
  wire [`ACS_RES_W-1:0] trial = conv_data | (12'h800 >> bit_cnt);
  wire [`ACS_RES_W-1:0] next_bit = (i_core_result >= trial) ? trial : conv_data;

  // ---------------------------------------------------------------
  // sequence state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      acs_pkg::ACS_IDLE: begin
        if (go_req) begin
          next_state = i_ctrl.converter_rc_clock_option ? acs_pkg::ACS_RC_WAIT
                                                        : acs_pkg::ACS_CONVERT;
        end
      end
      // counts system cycles so the wait does not depend on the rc tick phase
      acs_pkg::ACS_RC_WAIT: begin
        if (rc_cnt == 3'(`ACS_RC_DELAY_CYC - 1)) begin
          next_state = acs_pkg::ACS_CONVERT;
        end
      end
      acs_pkg::ACS_CONVERT: begin
        if (tick && bit_cnt == (`ACS_CONV_BITS - 4'h1)) begin
          next_state = acs_pkg::ACS_FINISH;
        end
      end
      acs_pkg::ACS_FINISH: begin
        if (tick) begin
          next_state = acs_pkg::ACS_COMPUTE;
        end
      end
      acs_pkg::ACS_COMPUTE: begin
        if (tick) begin
          next_state = acs_pkg::ACS_IDLE;
        end
      end
      default: begin
        next_state = acs_pkg::ACS_IDLE;
      end
    endcase
    if (!i_ctrl.enable) begin
      next_state = acs_pkg::ACS_IDLE;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state <= acs_pkg::ACS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bit and rc delay counters
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b || state == acs_pkg::ACS_IDLE) begin
      bit_cnt <= 4'h0;
      rc_cnt  <= 3'h0;
      conv_data <= 12'h000;
    end else begin
      if (state == acs_pkg::ACS_RC_WAIT) begin
        rc_cnt <= rc_cnt + 3'h1;
      end
      if (state == acs_pkg::ACS_CONVERT && tick) begin
        bit_cnt   <= bit_cnt + 4'h1;
        conv_data <= next_bit;
      end
    end
  end

  // captured raw result and sample strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      raw_result  <= 12'h000;
      core_sample <= 1'b0;
    end else begin
      core_sample <= (state == acs_pkg::ACS_CONVERT) & (bit_cnt == 4'h0);
      if (finishing) begin
        raw_result <= conv_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // start bit: held through the conversion, cleared at completion unless repeating
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b || !i_ctrl.enable) begin
      start_busy <= 1'b0;
    end else if (i_start_set || trig_fire || retrigger) begin
      start_busy <= 1'b1;
    end else if (computing && !i_ctrl.continuous_repeat) begin
      start_busy <= 1'b0;
    end else if (i_start_clr && state == acs_pkg::ACS_IDLE) begin
      start_busy <= 1'b0;
    end
  end

  // trigger edge memory and latch across sleep
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      trig_prev    <= 1'b0;
      trig_latched <= 1'b0;
    end else begin
      trig_prev <= trig_now;
      if (trig_rise && sleep_hold) begin
        trig_latched <= 1'b1;
      end else if (go_req) begin
        trig_latched <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // flags: hardware set wins over software clear
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      done_flag   <= 1'b0;
      math_flag   <= 1'b0;
      thresh_flag <= 1'b0;
    end else begin
      done_flag   <= computing | (done_flag & ~i_done_clr);
      math_flag   <= computing | (math_flag & ~i_math_clr);
      thresh_flag <= (test_now & thresh_hit) | (thresh_flag & ~i_thresh_clr);
    end
  end

  // result pair, previous result, sum and error
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      result_pair     <= `ACS_RST_RESULT;
      previous_result <= `ACS_RST_RESULT;
      sum_register    <= `ACS_RST_SUM;
      error_value     <= '0;
      sample_phase    <= 1'b0;
    end else begin
      if (computing) begin
        if (i_ctrl.previous_source_select) begin
          previous_result <= result_pair;
        end
        result_pair  <= new_result;
        sum_register <= sum_register + {8'h00, raw_result};
        sample_phase <= i_ctrl.double_sample_enable & ~sample_phase;
      end else if (i_result_wr) begin
        result_pair <= sw_result;
      end
      if (test_now) begin
        error_value <= err_calc;
      end
    end
  end

  // ---------------------------------------------------------------
  // sleep behaviour
  // ---------------------------------------------------------------
  // the enable bit keeps reading set while the converter sits off
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      conv_off   <= 1'b0;
      wake_req   <= 1'b0;
      vector_req <= 1'b0;
    end else begin
      if (computing && i_sleep && !i_ctrl.conversion_irq_enable) begin
        conv_off <= 1'b1;
      end else if (!i_sleep || !i_ctrl.enable) begin
        conv_off <= 1'b0;
      end
      wake_req   <= computing & i_sleep & i_ctrl.conversion_irq_enable;
      vector_req <= computing & i_ctrl.conversion_irq_enable
                  & i_ctrl.global_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_status <= '0;
    end else begin
      o_status <= '{start_busy, done_flag, math_flag, thresh_flag,
                    conv_off, wake_req, vector_req, trig_latched};
    end
  end

  // output registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_result_pair     <= `ACS_RST_RESULT;
      o_previous_result <= `ACS_RST_RESULT;
      o_sum_register    <= `ACS_RST_SUM;
      o_error_value     <= '0;
      o_core_sample     <= 1'b0;
      o_hold_discharge  <= 1'b0;
    end else begin
      o_result_pair     <= result_pair;
      o_previous_result <= previous_result;
      o_sum_register    <= sum_register;
      o_error_value     <= error_value;
      o_core_sample     <= core_sample;
      o_hold_discharge  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### acs_seq_asserts.sv
// checker for the conversion sequencer: flag, result and timing relations at the ports
// assumes a bind onto acs_sequencer, one clock domain, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module acs_seq_asserts (
  // clock and reset
  input wire logic               i_sys_clk,
  input wire logic               i_rst_b,
  // inputs watched
  input wire acs_pkg::acs_ctrl_t i_ctrl,
  input wire logic               i_sleep,
  input wire logic               i_done_clr,
  input wire logic               i_start_clr,
  // outputs watched
  input wire logic [15:0]        o_result_pair,
  input wire logic [15:0]        o_previous_result,
  input wire logic               o_hold_discharge,
  input wire acs_pkg::acs_stat_t o_status
);
  // ---------------------------------------------------------------
  // shorthand for the main status bits
  // ---------------------------------------------------------------
  wire logic dn;
  wire logic bz;
  assign dn = o_status.conversion_done_flag;
  assign bz = o_status.start_busy;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_hold; o_hold_discharge == 1'b0; endproperty
  a_hold: assert property (p_hold) else $error("hold discharge driven");
  property p_rst; disable iff (1'b0) (!i_rst_b) [*2] |=> o_status == '0 && o_result_pair == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("status not cleared by reset");
  property p_sticky; $fell(dn) |-> $past(i_done_clr) || $past(i_done_clr, 2) || $past(i_done_clr, 3);
  endproperty
  a_sticky: assert property (p_sticky) else $error("done flag fell by itself");
  property p_math; $rose(dn) |-> o_status.computation_pending_flag; endproperty
  a_math: assert property (p_math) else $error("pending flag missing at done");
  property p_bfall; $fell(bz) |-> dn || !$past(i_ctrl.enable) || !$past(i_ctrl.enable, 2)
    || $past(i_start_clr) || $past(i_start_clr, 2) || $past(i_start_clr, 3); endproperty
  a_bfall: assert property (p_bfall) else $error("busy cleared before completion");
  property p_bhold; $rose(bz) |-> (bz || !i_ctrl.enable) [*8]; endproperty
  a_bhold: assert property (p_bhold) else $error("busy too short");
  property p_dtime; $rose(bz) && !dn && !i_sleep && !i_ctrl.converter_rc_clock_option
    && i_ctrl.clock_divide == 6'h00 |-> ##[1:80] (dn || !i_ctrl.enable); endproperty
  a_dtime: assert property (p_dtime) else $error("conversion never completed");
  property p_left; $rose(dn) && i_ctrl.result_justify_select |-> o_result_pair[3:0] == 4'h0;
  endproperty
  a_left: assert property (p_left) else $error("left result low nibble set");
  property p_right; $rose(dn) && !i_ctrl.result_justify_select |-> o_result_pair[15:12] == 4'h0;
  endproperty
  a_right: assert property (p_right) else $error("right result high nibble set");
  property p_prev; $rose(dn) && i_ctrl.previous_source_select
    |-> o_previous_result == $past(o_result_pair); endproperty
  a_prev: assert property (p_prev) else $error("previous result not moved");
  property p_thr; $rose(o_status.threshold_irq_flag) |-> dn; endproperty
  a_thr: assert property (p_thr) else $error("threshold flag before done");
endmodule
bind acs_sequencer acs_seq_asserts i_chk (.i_sys_clk, .i_rst_b, .i_ctrl, .i_sleep, .i_done_clr,
  .i_start_clr, .o_result_pair, .o_previous_result, .o_hold_discharge, .o_status);
`default_nettype wire

// ### tb_top.sv
// testbench for the conversion sequencer: directed call sequences with expected values
// assumes acs_pkg and acs_sequencer are compiled first; 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               clk = 1'b0, rst_b = 1'b0, rc_tick = 1'b0, sleep = 1'b0;
  logic               start_set = 1'b0, start_clr = 1'b0, done_clr = 1'b0;
  logic               math_clr = 1'b0, thresh_clr = 1'b0, res_wr = 1'b0;
  logic [11:0]        wdata = 12'h000, setpoint = 12'h000, thresh = 12'h000, core = 12'h000;
  logic [31:0]        trig = 32'h0;
  logic [1:0]         rc_cnt = 2'h0;
  acs_pkg::acs_ctrl_t ctrl = '0;
  acs_pkg::acs_stat_t st;
  acs_pkg::acs_stat_t st_done;
  logic               samp, samp_d = 1'b0;
  int                 n_samp = 0;
  logic [15:0]        res, prev;
  logic [19:0]        sum;
  logic [12:0]        err;
  int                 n_fail = 0, compares = 0;
  // ---------------------------------------------------------------
  // clock, rc oscillator tick every fourth cycle, design
  // ---------------------------------------------------------------
  always #50 clk = ~clk;
  always @(posedge clk) begin
    #10;
    rc_cnt = rc_cnt + 2'h1;
    rc_tick = (rc_cnt == 2'h0);
  end
  // count conversion starts seen on the core sample strobe
  always @(posedge clk) begin
    samp_d <= samp;
    if (samp === 1'b1 && samp_d !== 1'b1) begin
      n_samp <= n_samp + 1;
    end
  end
  acs_sequencer i_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_rc_tick(rc_tick), .i_ctrl(ctrl),
    .i_sleep(sleep), .i_start_set(start_set), .i_start_clr(start_clr), .i_done_clr(done_clr),
    .i_math_clr(math_clr), .i_thresh_clr(thresh_clr), .i_result_wr(res_wr),
    .i_result_wdata(wdata), .i_trig_sources(trig), .i_setpoint(setpoint), .i_threshold(thresh),
    .i_core_result(core), .o_core_sample(samp), .o_hold_discharge(), .o_result_pair(res),
    .o_previous_result(prev), .o_sum_register(sum), .o_error_value(err), .o_status(st));
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go();
    start_set = 1'b1;
    cyc(1);
    start_set = 1'b0;
  endtask
  task automatic clr_flags();
    {done_clr, math_clr, thresh_clr} = 3'h7;
    cyc(1);
    {done_clr, math_clr, thresh_clr} = 3'h0;
    cyc(3);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (st.conversion_done_flag !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    st_done = st;
    chk(k < 300, 1'b1);
    cyc(3);
  endtask
  task automatic conv(input logic [11:0] v);
    core = v;
    clr_flags();
    go();
    wait_done();
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    #3000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    cyc(3);
    rst_b = 1'b1;
    chk(st, 8'h00);
    ctrl.enable = 1'b1;
    cyc(2);
    core = 12'habc;
    clr_flags();
    go();
    cyc(2);
    chk(st.start_busy, 1'b1);
    wait_done();
    chk(res, 16'h0abc);
    chk({st.start_busy, st.computation_pending_flag}, 2'h1);
    chk(n_samp, 32'h1);
    cyc(10);
    chk(st.conversion_done_flag, 1'b1);
    ctrl.previous_source_select = 1'b1;
    conv(12'h123);
    chk({res, prev}, 32'h0123_0abc);
    chk(sum, 20'h00bdf);
    ctrl.previous_source_select = 1'b0;
    ctrl.result_justify_select = 1'b1;
    wdata = 12'h456;
    res_wr = 1'b1;
    cyc(1);
    res_wr = 1'b0;
    cyc(3);
    chk(res, 16'h4560);
    conv(12'h789);
    chk(res, 16'h7890);
    ctrl.result_justify_select = 1'b0;
    ctrl.trigger_source_select = 5'h03;
    clr_flags();
    trig = 32'h20;
    cyc(60);
    chk(st.conversion_done_flag, 1'b0);
    trig = 32'h28;
    wait_done();
    trig = 32'h0;
    setpoint = 12'h100;
    thresh = 12'h010;
    conv(12'h200);
    chk({st.threshold_irq_flag, err}, {1'b1, 13'h0100});
    conv(12'h105);
    chk({st.threshold_irq_flag, err}, {1'b0, 13'h0005});
    ctrl.double_sample_enable = 1'b1;
    conv(12'h200);
    chk({st.threshold_irq_flag, err}, {1'b0, 13'h0005});
    conv(12'h200);
    chk({st.threshold_irq_flag, err}, {1'b1, 13'h0100});
    ctrl.double_sample_enable = 1'b0;
    ctrl.continuous_repeat = 1'b1;
    conv(12'h321);
    chk(st.start_busy, 1'b1);
    ctrl.enable = 1'b0;
    cyc(6);
    chk(st.start_busy, 1'b0);
    ctrl.continuous_repeat = 1'b0;
    ctrl.enable = 1'b1;
    clr_flags();
    sleep = 1'b1;
    trig = 32'h8;
    cyc(60);
    chk({st.conversion_done_flag, st.trigger_latched}, 2'h1);
    sleep = 1'b0;
    wait_done();
    trig = 32'h0;
    ctrl.converter_rc_clock_option = 1'b1;
    clr_flags();
    sleep = 1'b1;
    trig = 32'h8;
    wait_done();
    chk({st.converter_off, st_done.wake_request, st_done.vector_request}, 3'h4);
    sleep = 1'b0;
    trig = 32'h0;
    ctrl.conversion_irq_enable = 1'b1;
    cyc(2);
    sleep = 1'b1;
    conv(12'h0f0);
    chk({st.converter_off, st_done.wake_request, st_done.vector_request}, 3'h2);
    ctrl.global_irq_enable = 1'b1;
    conv(12'h0f0);
    chk({st.converter_off, st_done.wake_request, st_done.vector_request}, 3'h3);
    sleep = 1'b0;
    ctrl.converter_rc_clock_option = 1'b0;
    cyc(4);
    go();
    cyc(5);
    rst_b = 1'b0;
    cyc(3);
    rst_b = 1'b1;
    cyc(1);
    chk({st.start_busy, res}, 17'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
